// File: logic/lrs_consts.vh
// constants for the logic rule scan engine: timing, register offsets and field layout
`ifndef LRS_CONSTS_VH
`define LRS_CONSTS_VH

// timing, figures in their own units
`define LRS_CLK_MHZ       100
`define LRS_SCAN_BASE_US  600
`define LRS_RULE_US       370
`define LRS_MS_US         1000
// the same figures as clock cycles at 100 MHz, sized for the pacing counters
`define LRS_BASE_CYC      24'h00ea60
`define LRS_RULE_CYC      24'h009088
`define LRS_MS_CYC        17'h186a0

// single registers, byte addresses
`define LRS_A_CTRL        9'h000
`define LRS_A_STATUS      9'h004
`define LRS_A_FLAGS       9'h008
`define LRS_A_DOUT        9'h00c
`define LRS_A_SCANS       9'h010

// per-rule pages, selected by address bits 8:6, word index in bits 5:2
`define LRS_PG_IN         3'h4
`define LRS_PG_OUT        3'h5
`define LRS_PG_WIN        3'h6
`define LRS_PG_TMR        3'h7

// control register bits
`define LRS_CTRL_RUN      0
`define LRS_CTRL_CLEAR    1

// input config word: three 8-bit selectors, operator, enable
`define LRS_IN_OP_LSB     24
`define LRS_IN_EN_BIT     26

// input selector types, bits 7:5 of a selector; bit 4 inverts, bits 3:0 index (bits 2:0 for an analog channel)
`define LRS_SRC_OFF       3'h0
`define LRS_SRC_DI        3'h1
`define LRS_SRC_FLAG      3'h2
`define LRS_SRC_RFLAG     3'h3
`define LRS_SRC_ANALOG    3'h4
`define LRS_SRC_TIMER     3'h5

// logic operators
`define LRS_OP_AND        2'h0
`define LRS_OP_OR         2'h1
`define LRS_OP_NAND       2'h2
`define LRS_OP_NOR        2'h3

// output config word: type 2:0, true value 3, index 7:4, latch 8
`define LRS_OUT_TV_BIT    3
`define LRS_OUT_LATCH_BIT 8
`define LRS_DST_NONE      3'h0
`define LRS_DST_DO        3'h1
`define LRS_DST_FLAG      3'h2
`define LRS_DST_RFLAG     3'h3
`define LRS_DST_TIMER     3'h4

`endif

// File: logic/lrs_engine.v
// logic rule scan engine with avalon-mm register slave
//
// Our own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "lrs_consts.vh"
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module lrs_engine #(
  parameter [23:0] BASE_CYC = `LRS_BASE_CYC,
  parameter [23:0] RULE_CYC = `LRS_RULE_CYC,
  parameter [16:0] MS_CYC   = `LRS_MS_CYC
) (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst_b,
  // avalon-mm register slave
  input  wire [8:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata_ff,
  output reg         avs_waitrequest_ff,
  // field i/o
  input  wire [15:0] di_in,
  input  wire [127:0] ai_in,
  output reg  [15:0] do_out_ff,
  // remote peer flags
  input  wire [15:0] remote_flag_in,
  output reg         rmt_wr_ff,
  output reg  [3:0]  rmt_idx_ff,
  output reg         rmt_val_ff,
  // run state
  output reg         run_active_ff
);

  localparam [4:0] ST_IDLE  = 5'h01;
  localparam [4:0] ST_LOGIC = 5'h02;
  localparam [4:0] ST_EXEC  = 5'h04;
  localparam [4:0] ST_OUTP  = 5'h08;
  localparam [4:0] ST_WAIT  = 5'h10;

  reg [26:0] in_cfg_ff [0:15];
  reg [8:0]  out_cfg_ff [0:15];
  reg [31:0] win_ff [0:15];
  reg [15:0] preset_ff [0:15];
  reg [15:0] tmr_ff [0:15];
  reg [15:0] tmr_run_ff;
  reg [15:0] flag_ff;
  reg [15:0] logic_ff;
  reg [15:0] exec_ff;
  reg [4:0]  state_ff;
  reg [3:0]  idx_ff;
  reg [23:0] cyc_ff;
  reg [16:0] ms_ff;
  reg        ms_tick_ff;
  reg [31:0] scans_ff;
  reg        run_cmd_ff;
  reg [31:0] nxt_rdata;
  reg [15:0] en_vec;
  reg [23:0] scan_len;
  integer    i;
  integer    j;

  wire       wr_go = avs_write & ~avs_waitrequest_ff;
  wire [2:0] pg    = avs_address[8:6];
  wire [3:0] pidx  = avs_address[5:2];

  //////////////////////////////////////////////////////////////////////////////
  // one input selector: source pick plus optional inversion
  function in_val;
    input [7:0]  sel;
    input [31:0] win;
    reg   [15:0] ai;
    reg          v;
    begin
      ai = ai_in[{sel[2:0], 4'h0} +: 16];
      case (sel[7:5])
        `LRS_SRC_DI:     v = di_in[sel[3:0]];
        `LRS_SRC_FLAG:   v = flag_ff[sel[3:0]];
        `LRS_SRC_RFLAG:  v = remote_flag_in[sel[3:0]];
        `LRS_SRC_ANALOG: v = (ai >= win[15:0]) && (ai <= win[31:16]);
        `LRS_SRC_TIMER:  v = tmr_run_ff[sel[3:0]] && (tmr_ff[sel[3:0]] >= preset_ff[sel[3:0]]);
        default:         v = 1'b0;
      endcase
      in_val = v ^ sel[4];
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // whole input-and-logic stage of one rule; unused inputs are neutral for the operator
  function rule_eval;
    input [26:0] cfg;
    input [31:0] win;
    reg   [2:0]  v;
    reg          and_op;
    reg          r;
    integer      k;
    begin
      and_op = (cfg[`LRS_IN_OP_LSB +: 2] == `LRS_OP_AND) || (cfg[`LRS_IN_OP_LSB +: 2] == `LRS_OP_NAND);
      for (k = 0; k < 3; k = k + 1) begin
        if (cfg[8*k+5 +: 3] == `LRS_SRC_OFF) begin
          v[k] = and_op;
        end else begin
          v[k] = in_val(cfg[8*k +: 8], win);
        end
      end
      r = and_op ? (&v) : (|v);
      rule_eval = cfg[`LRS_IN_OP_LSB + 1] ? ~r : r;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // enabled-rule vector and scan length, used by pacing and status
  always @* begin
    for (j = 0; j < 16; j = j + 1) begin
      en_vec[j] = in_cfg_ff[j][`LRS_IN_EN_BIT];
    end
  end

  // popcount of enables, counted once more for the status word
  function [4:0] count_en;
    input [15:0] v;
    integer k;
    begin
      count_en = 5'h00;
      for (k = 0; k < 16; k = k + 1) begin
        count_en = count_en + {4'h0, v[k]};
      end
    end
  endfunction

  // pacing: the scan is stretched to base time plus a slot per enabled rule
  always @* begin
    scan_len = BASE_CYC + RULE_CYC * {19'h0, count_en(en_vec)};
  end

  //////////////////////////////////////////////////////////////////////////////
  // register read mux; unmapped addresses read zero
  always @* begin
    nxt_rdata = 32'h0000_0000;
    if (avs_address == `LRS_A_CTRL) begin
      nxt_rdata = {31'h0, run_cmd_ff};
    end else if (avs_address == `LRS_A_STATUS) begin
      nxt_rdata = {17'h0, count_en(en_vec), idx_ff, state_ff, run_active_ff};
    end else if (avs_address == `LRS_A_FLAGS) begin
      nxt_rdata = {16'h0, flag_ff};
    end else if (avs_address == `LRS_A_DOUT) begin
      nxt_rdata = {16'h0, do_out_ff};
    end else if (avs_address == `LRS_A_SCANS) begin
      nxt_rdata = scans_ff;
    end else if (pg == `LRS_PG_IN) begin
      nxt_rdata = {5'h0, in_cfg_ff[pidx]};
    end else if (pg == `LRS_PG_OUT) begin
      nxt_rdata = {23'h0, out_cfg_ff[pidx]};
    end else if (pg == `LRS_PG_WIN) begin
      nxt_rdata = win_ff[pidx];
    end else if (pg == `LRS_PG_TMR) begin
      nxt_rdata = {tmr_ff[pidx], preset_ff[pidx]};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, then a single cycle with waitrequest low
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest_ff <= 1'b1;
      avs_readdata_ff    <= 32'h0000_0000;
    end else if ((avs_read | avs_write) & avs_waitrequest_ff) begin
      avs_waitrequest_ff <= 1'b0;
      avs_readdata_ff    <= nxt_rdata;
    end else begin
      avs_waitrequest_ff <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // millisecond time base for rule timers
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ms_ff      <= 17'h00000;
      ms_tick_ff <= 1'b0;
    end else if (ms_ff >= MS_CYC - 17'h00001) begin
      ms_ff      <= 17'h00000;
      ms_tick_ff <= 1'b1;
    end else begin
      ms_ff      <= ms_ff + 17'h00001;
      ms_tick_ff <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // scan engine, configuration store and flags share one process because
  // host writes and the output phase both touch flags and rule settings
  always @(posedge ref_clk or negedge rst_b) begin : engine
    reg [8:0] oc;
    reg       val;
    if (!rst_b) begin
      for (i = 0; i < 16; i = i + 1) begin
        in_cfg_ff[i]  <= 27'h0;
        out_cfg_ff[i] <= 9'h000;
        win_ff[i]     <= 32'h0000_0000;
        preset_ff[i]  <= 16'h0000;
        tmr_ff[i]     <= 16'h0000;
      end
      tmr_run_ff    <= 16'h0000;
      flag_ff       <= 16'h0000;
      logic_ff      <= 16'h0000;
      exec_ff       <= 16'h0000;
      do_out_ff     <= 16'h0000;
      state_ff      <= ST_IDLE;
      idx_ff        <= 4'h0;
      cyc_ff        <= 24'h000000;
      scans_ff      <= 32'h0000_0000;
      run_cmd_ff    <= 1'b0;
      run_active_ff <= 1'b0;
      rmt_wr_ff     <= 1'b0;
      rmt_idx_ff    <= 4'h0;
      rmt_val_ff    <= 1'b0;
    end else begin
      oc        = out_cfg_ff[idx_ff];
      val       = exec_ff[idx_ff] ? oc[`LRS_OUT_TV_BIT] : ~oc[`LRS_OUT_TV_BIT];
      rmt_wr_ff <= 1'b0;
      cyc_ff    <= cyc_ff + 24'h000001;
      // running timers count whole milliseconds and saturate
      for (i = 0; i < 16; i = i + 1) begin
        if (tmr_run_ff[i] && ms_tick_ff && (tmr_ff[i] != 16'hffff)) begin
          tmr_ff[i] <= tmr_ff[i] + 16'h0001;
        end
      end
      case (state_ff)
        ST_IDLE: begin
          run_active_ff <= 1'b0;
          if (run_cmd_ff) begin
            flag_ff       <= 16'h0000;
            tmr_run_ff    <= 16'h0000;
            for (i = 0; i < 16; i = i + 1) begin
              tmr_ff[i] <= 16'h0000;
            end
            run_active_ff <= 1'b1;
            idx_ff        <= 4'h0;
            cyc_ff        <= 24'h000000;
            state_ff      <= ST_LOGIC;
          end
        end
        ST_LOGIC: begin
          // every enabled rule samples inputs before any output of this scan
          if (en_vec[idx_ff]) begin
            logic_ff[idx_ff] <= rule_eval(in_cfg_ff[idx_ff], win_ff[idx_ff]);
          end
          idx_ff <= idx_ff + 4'h1;
          if (idx_ff == 4'hf) begin
            state_ff <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (en_vec[idx_ff]) begin
            exec_ff[idx_ff] <= logic_ff[idx_ff];
          end
          idx_ff <= idx_ff + 4'h1;
          if (idx_ff == 4'hf) begin
            state_ff <= ST_OUTP;
          end
        end
        ST_OUTP: begin
          // latch mode acts only on a true result, so outputs accumulate
          if (en_vec[idx_ff] && (!oc[`LRS_OUT_LATCH_BIT] || exec_ff[idx_ff])) begin
            case (oc[2:0])
              `LRS_DST_DO: begin
                do_out_ff[oc[7:4]] <= val;
              end
              `LRS_DST_FLAG: begin
                flag_ff[oc[7:4]] <= val;
              end
              `LRS_DST_RFLAG: begin
                rmt_wr_ff  <= 1'b1;
                rmt_idx_ff <= oc[7:4];
                rmt_val_ff <= val;
              end
              `LRS_DST_TIMER: begin
                // true starts counting, false stops and zeroes the timer
                tmr_run_ff[oc[7:4]] <= val;
                if (!val) begin
                  tmr_ff[oc[7:4]] <= 16'h0000;
                end
              end
              default: begin
                rmt_wr_ff <= 1'b0;
              end
            endcase
          end
          idx_ff <= idx_ff + 4'h1;
          if (idx_ff == 4'hf) begin
            state_ff <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (cyc_ff >= scan_len - 24'h000001) begin
            cyc_ff   <= 24'h000000;
            scans_ff <= scans_ff + 32'h0000_0001;
            state_ff <= ST_LOGIC;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
      // a stop command takes effect at once, whatever phase is in progress
      // no remote write may leave once the engine reports itself stopped
      if (!run_cmd_ff && (state_ff != ST_IDLE)) begin
        state_ff      <= ST_IDLE;
        run_active_ff <= 1'b0;
        rmt_wr_ff     <= 1'b0;
      end
      // host writes come last so a host flag write overrides the output phase
      if (wr_go) begin
        if (avs_address == `LRS_A_CTRL) begin
          run_cmd_ff <= avs_writedata[`LRS_CTRL_RUN];
          if (avs_writedata[`LRS_CTRL_CLEAR]) begin
            for (i = 0; i < 16; i = i + 1) begin
              in_cfg_ff[i]  <= 27'h0;
              out_cfg_ff[i] <= 9'h000;
            end
          end
        end else if (avs_address == `LRS_A_FLAGS) begin
          flag_ff <= avs_writedata[15:0];
        end else if (pg == `LRS_PG_IN) begin
          in_cfg_ff[pidx] <= avs_writedata[26:0];
        end else if (pg == `LRS_PG_OUT) begin
          out_cfg_ff[pidx] <= avs_writedata[8:0];
        end else if (pg == `LRS_PG_WIN) begin
          win_ff[pidx] <= avs_writedata;
        end else if (pg == `LRS_PG_TMR) begin
          preset_ff[pidx] <= avs_writedata[15:0];
        end
      end
    end
  end

endmodule // lrs_engine

// File: test/lrs_peer.sv
// remote peer model: holds the flags that the engine writes and reads
`timescale 1ns/1ps
module lrs_peer (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst_b,
  // flag writes from the engine
  input  wire        rmt_wr_ff,
  input  wire [3:0]  rmt_idx_ff,
  input  wire        rmt_val_ff,
  // flags as the engine sees them
  output logic [15:0] remote_flag_in
);
  logic [15:0] held_ff;
  //////////////////////////////////////////////////////////////////////////////
  // each written flag is held and returned to the engine on remote_flag_in until rewritten
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) held_ff <= 16'h0000;
    else if (rmt_wr_ff) held_ff[rmt_idx_ff] <= rmt_val_ff;
  end
  assign remote_flag_in = held_ff;
endmodule // lrs_peer

// File: test/lrs_engine_sva.sv
// assertions and covers on the scan engine ports
`timescale 1ns/1ps
module lrs_engine_sva (
  // clock and reset
  input wire        ref_clk,
  input wire        rst_b,
  // register bus
  input wire [8:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata_ff,
  input wire        avs_waitrequest_ff,
  // outputs
  input wire [15:0] do_out_ff,
  input wire        rmt_wr_ff,
  input wire [3:0]  rmt_idx_ff,
  input wire        rmt_val_ff,
  input wire        run_active_ff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic [2:0] since_ctrl_ff;
  // a control write takes effect at this edge
  wire        ctrl_wr = avs_write && !avs_waitrequest_ff && avs_address == 9'h000;
  //////////////////////////////////////////////////////////////////////////////
  // cycles since a control write was applied, saturating so it never wraps
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) since_ctrl_ff <= 3'h7;
    else if (ctrl_wr) since_ctrl_ff <= 3'h0;
    else if (since_ctrl_ff != 3'h7) since_ctrl_ff <= since_ctrl_ff + 3'h1;
  end
  //////////////////////////////////////////////////////////////////////////////
  wait_pulse_a: assert property (!avs_waitrequest_ff |=> avs_waitrequest_ff)
    else $error("waitrequest low for more than one cycle");
  answer_time_a: assert property ((avs_read || avs_write) && avs_waitrequest_ff |=> !avs_waitrequest_ff)
    else $error("access not answered after one edge");
  idle_hold_a: assert property (!avs_read && !avs_write && avs_waitrequest_ff |=> avs_waitrequest_ff)
    else $error("answer without a request");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest_ff && avs_address == 9'h014 |-> avs_readdata_ff == 32'h0)
    else $error("unmapped read not zero");
  readdata_hold_a: assert property (avs_waitrequest_ff |-> $stable(avs_readdata_ff))
    else $error("read data moved outside an answer");
  remote_run_a: assert property (rmt_wr_ff |-> run_active_ff)
    else $error("remote write while stopped");
  rmt_hold_a: assert property (!rmt_wr_ff |-> $stable(rmt_idx_ff) && $stable(rmt_val_ff))
    else $error("remote index or value moved without a write");
  dout_idle_a: assert property (!run_active_ff && !$past(run_active_ff) |-> $stable(do_out_ff))
    else $error("outputs changed while stopped");
  run_cause_a: assert property ($changed(run_active_ff) |-> since_ctrl_ff < 3'h4)
    else $error("run state changed without a control write");
  run_start_a: assert property (ctrl_wr && avs_writedata[0] |=> ##1 run_active_ff)
    else $error("run command not reported as running");
  run_stop_a: assert property (ctrl_wr && !avs_writedata[0] |=> ##1 !run_active_ff)
    else $error("stop command not reported as stopped");
  cover property (rmt_wr_ff);
  cover property ($rose(run_active_ff));
  cover property (avs_read && !avs_waitrequest_ff && avs_address == 9'h014);
  cover property (do_out_ff[2] && do_out_ff[3]);
endmodule // lrs_engine_sva

// File: test/test_lrs_engine.sv
// self-checking bench for the scan engine with a remote peer model
`timescale 1ns/1ps
module test_lrs_engine;
  logic        ref_clk, rst_b, avs_read, avs_write, avs_waitrequest_ff;
  logic        rmt_wr_ff, rmt_val_ff, run_active_ff;
  logic [8:0]  avs_address;
  logic [3:0]  rmt_idx_ff;
  logic [15:0] di_in, do_out_ff, remote_flag_in, lf;
  logic [31:0] avs_writedata, avs_readdata_ff, q, p;
  logic [127:0] ai_in;
  int          bad_count, compares, cyc, t0;
  logic [40:0] cfg [20] = '{
    {9'h100, 32'h0400_0080}, {9'h140, 32'h00a}, {9'h104, 32'h0400_0081}, {9'h144, 32'h01a},
    {9'h108, 32'h0500_4140}, {9'h148, 32'h009}, {9'h10c, 32'h0400_0020}, {9'h14c, 32'h12a},
    {9'h110, 32'h0400_3142}, {9'h150, 32'h019}, {9'h114, 32'h0400_0021}, {9'h154, 32'h122},
    {9'h118, 32'h0600_0043}, {9'h158, 32'h03a}, {9'h11c, 32'h0400_0065}, {9'h15c, 32'h09b},
    {9'h120, 32'h0400_0022}, {9'h160, 32'h05b}, {9'h180, 32'h5000_3000}, {9'h184, 32'h5000_3000}};
  logic [31:0] pair [3] = '{32'h0000_3000, 32'h5001_5000, 32'h5001_2fff};
  // sequential setup: input 0 latches output 2 and starts timer 0, timer done (nor of inverse) latches output 3
  logic [40:0] seq [6] = '{
    {9'h124, 32'h0400_0020}, {9'h164, 32'h129}, {9'h128, 32'h0400_0020}, {9'h168, 32'h10c},
    {9'h12c, 32'h0700_00b0}, {9'h16c, 32'h139}};

  lrs_engine #(.BASE_CYC(24'h28), .RULE_CYC(24'h0a), .MS_CYC(17'h14)) u_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata_ff(avs_readdata_ff),
    .avs_waitrequest_ff(avs_waitrequest_ff), .di_in(di_in), .ai_in(ai_in), .do_out_ff(do_out_ff),
    .remote_flag_in(remote_flag_in), .rmt_wr_ff(rmt_wr_ff), .rmt_idx_ff(rmt_idx_ff),
    .rmt_val_ff(rmt_val_ff), .run_active_ff(run_active_ff));
  lrs_peer u_peer (.ref_clk(ref_clk), .rst_b(rst_b), .rmt_wr_ff(rmt_wr_ff), .rmt_idx_ff(rmt_idx_ff),
    .rmt_val_ff(rmt_val_ff), .remote_flag_in(remote_flag_in));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] nxt_lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // inclusive window, the bounds programmed into both windows
  function automatic logic in_win(input logic [15:0] v);
    return v >= 16'h3000 && v <= 16'h5000;
  endfunction
  // one bus access; request held until waitrequest is sampled low at a rising edge, data taken there,
  // then one idle edge so the next call never reassigns a strobe in the same time step
  task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d, output logic [31:0] r);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge ref_clk); while (avs_waitrequest_ff !== 1'b0);
    r = avs_readdata_ff;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdc(input string nm, input logic [8:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(nm, e, r & m);
  endtask
  // returns just after the scan counter has advanced by k
  task automatic scans(input int k);
    logic [31:0] b, r;
    bus(1'b0, 9'h010, 32'h0, b);
    do bus(1'b0, 9'h010, 32'h0, r); while (!(r >= b + k));
  endtask
  task automatic summarize();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // hang guard, well above the few thousand cycles the run needs
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    rst_b = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 9'h000; avs_writedata = 32'h0;
    di_in = 16'h0000; ai_in = {96'h0, 32'h4000_4000}; lf = 16'h0043;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rdc("status run", 9'h004, 32'h1, 32'h0);
    rdc("unmapped", 9'h014, 32'hffffffff, 32'h0);
    for (int i = 0; i < 20; i++) wr(cfg[i][40:32], cfg[i][31:0]);
    rdc("enabled count", 9'h004, 32'h7c00, 32'h9 << 10);
    wr(9'h000, 32'h1);
    rdc("status run", 9'h004, 32'h1, 32'h1);
    // flags set in scan one reach the or rule only in scan two
    scans(1);
    rdc("dout cascade", 9'h00c, 32'h1, 32'h0);
    rdc("feedback", 9'h008, 32'h8, 32'h8);
    scans(1);
    rdc("dout cascade", 9'h00c, 32'h1, 32'h1);
    rdc("feedback", 9'h008, 32'h8, 32'h0);
    // window corners first, then random levels on both channels
    for (int i = 0; i < 8; i++) begin
      lf = nxt_lfsr(lf);
      p[15:0] = {1'b0, lf[14:0]};
      lf = nxt_lfsr(lf);
      p[31:16] = {1'b0, lf[14:0]};
      if (i < 3) p = pair[i];
      ai_in <= {96'h0, p};
      scans(3);
      rdc("dout window", 9'h00c, 32'h1, {31'h0, in_win(p[15:0]) | in_win(p[31:16])});
    end
    // on/off pair: set latches, inverted stop input clears
    di_in <= 16'h0001;
    scans(3);
    rdc("dout on", 9'h00c, 32'h2, 32'h2);
    di_in <= 16'h0000;
    scans(3);
    rdc("dout held", 9'h00c, 32'h2, 32'h2);
    di_in <= 16'h0002;
    scans(3);
    rdc("dout off", 9'h00c, 32'h2, 32'h0);
    di_in <= 16'h0000;
    scans(3);
    rdc("dout stays off", 9'h00c, 32'h2, 32'h0);
    wr(9'h008, 32'h4);
    scans(3);
    rdc("dout host flag", 9'h00c, 32'h2, 32'h2);
    // remote chain through the peer in both directions
    chk("peer flags", 32'h0, {16'h0, u_peer.held_ff & 16'h0220});
    di_in <= 16'h0004;
    scans(3);
    chk("peer flags", 32'h0220, {16'h0, u_peer.held_ff & 16'h0220});
    // clear keeps running but leaves every rule idle
    wr(9'h000, 32'h3);
    rdc("in cfg", 9'h100, 32'h0400_0000, 32'h0);
    rdc("enabled count", 9'h004, 32'h7c00, 32'h0);
    bus(1'b0, 9'h00c, 32'h0, q);
    di_in <= 16'h0003;
    ai_in <= 128'h0;
    scans(3);
    rdc("dout skipped", 9'h00c, 32'hffff, q);
    wr(9'h000, 32'h0);
    rdc("status run", 9'h004, 32'h1, 32'h0);
    wr(9'h008, 32'h00f0);
    wr(9'h000, 32'h1);
    rdc("flags cleared", 9'h008, 32'hffff, 32'h0);
    // sequential setup; preset of 8 ms keeps output 3 off for the first two scans after the trigger
    di_in <= 16'h0000;
    wr(9'h1c0, 32'h0000_0008);
    rdc("timer preset", 9'h1c0, 32'hffff, 32'h8);
    for (int i = 0; i < 6; i++) wr(seq[i][40:32], seq[i][31:0]);
    scans(2);
    rdc("seq idle", 9'h00c, 32'hc, 32'h0);
    di_in <= 16'h0001;
    scans(2);
    t0 = cyc;
    rdc("seq first", 9'h00c, 32'hc, 32'h4);
    di_in <= 16'h0000;
    scans(4);
    // three enabled rules: 40 + 3 * 10 cycles a scan, polling adds a few cycles either way
    chk("scan period", 32'h1, {31'h0, (cyc - t0 >= 276) && (cyc - t0 <= 284)});
    rdc("seq accumulate", 9'h00c, 32'hc, 32'hc);
    summarize();
  end
endmodule // test_lrs_engine

bind lrs_engine lrs_engine_sva u_sva (.ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata_ff(avs_readdata_ff),
  .avs_waitrequest_ff(avs_waitrequest_ff), .do_out_ff(do_out_ff), .rmt_wr_ff(rmt_wr_ff),
  .rmt_idx_ff(rmt_idx_ff), .rmt_val_ff(rmt_val_ff), .run_active_ff(run_active_ff));
